/* rtl/mbdc_defines.vh */
// constants for the module base decode and configuration block
// assumes inclusion by the verilog-2005 rtl and the systemverilog testbench; definitions only
`ifndef MBDC_DEFINES_VH
`define MBDC_DEFINES_VH

// ==========================================================
// base locator access point (byte addresses, cpu space)
`define MBDC_BASELOC_ADDR 32'h0003FF00
`define MBDC_BASELOC_HI_ADDR 32'h0003FF00
`define MBDC_BASELOC_LO_ADDR 32'h0003FF02
`define MBDC_BASELOC_RESET 32'h00000000

// ==========================================================
// function code values
`define MBDC_FC_CPU 4'h7
`define MBDC_FC_SUP_DATA 4'h5

// ==========================================================
// low half field positions
`define MBDC_LO_VALID_BIT 0
`define MBDC_LO_MASK_LSB 1
`define MBDC_LO_MASK_MSB 9
`define MBDC_LO_BASE_LSB 12

// ==========================================================
// offsets inside the 4-kbyte block
`define MBDC_UCFG_OFFSET 12'h000
`define MBDC_SHARED_LO 12'h010
`define MBDC_SHARED_HI 12'h01F

// ==========================================================
// unit_config fields and reset value
`define MBDC_UCFG_TIMERS_BIT 14
`define MBDC_UCFG_BUSMON_BIT 13
`define MBDC_UCFG_FULL_IRQ_SELECT_BIT 12
`define MBDC_UCFG_MIRROR_MSB 9
`define MBDC_UCFG_MIRROR_LSB 8
`define MBDC_UCFG_PRIV_BIT 7
`define MBDC_UCFG_IRQ_PRIORITY_FIELD_MSB 3
`define MBDC_UCFG_WMASK 16'h738F
`define MBDC_UCFG_RESET 16'h008F

`endif

/* rtl/mbdc_show_cycle.v */
// show-cycle driver: mirrors one internal transfer onto the external pins
// assumes starts come from the same clock and at least four cycles apart
`timescale 1ns/1ps
`default_nettype none

module mbdc_show_cycle (
    input wire clk,
    input wire rst_b,
    input wire start,
    input wire [31:0] showAddr,
    input wire [31:0] showData,
    output reg [31:0] extAddr,
    output reg extAddrOe,
    output reg [31:0] extData,
    output reg extDataOe,
    output reg extDataStrobe_b,
    output wire extAddrStrobe_b,
    output wire busy
);

    // ==========================================================
    // state machine
    localparam [3:0] SHOW_IDLE = 4'b0001;
    localparam [3:0] SHOW_ADDR = 4'b0010;
    localparam [3:0] SHOW_DATA = 4'b0100;
    localparam [3:0] SHOW_HOLD = 4'b1000;

    reg [3:0] state;
    reg [3:0] next_state;

    // address strobe is never asserted by a show cycle
    assign extAddrStrobe_b = 1'b1;
    assign busy = (state != SHOW_IDLE);

    // next state selection
    always @* begin
        case (state)
            SHOW_IDLE: next_state = start ? SHOW_ADDR : SHOW_IDLE;
            SHOW_ADDR: next_state = SHOW_DATA;
            SHOW_DATA: next_state = SHOW_HOLD;
            SHOW_HOLD: next_state = SHOW_IDLE;
            default: next_state = SHOW_IDLE;
        endcase
    end

    // pin drivers: strobe low for address phase, data set up at its negation
    always @(posedge clk) begin
        if (!rst_b) begin
            state <= SHOW_IDLE;
            extAddr <= 32'h00000000;
            extAddrOe <= 1'b0;
            extData <= 32'h00000000;
            extDataOe <= 1'b0;
            extDataStrobe_b <= 1'b1;
        end else begin
            state <= next_state;
            case (next_state)
                SHOW_ADDR: begin
                    extAddr <= showAddr;
                    extData <= showData;
                    extAddrOe <= 1'b1;
                    extDataOe <= 1'b1;
                    extDataStrobe_b <= 1'b0;
                end
                SHOW_DATA: begin
                    extDataStrobe_b <= 1'b1;
                end
                SHOW_HOLD: begin
                    extDataStrobe_b <= 1'b1;
                end
                default: begin
                    extAddrOe <= 1'b0;
                    extDataOe <= 1'b0;
                    extDataStrobe_b <= 1'b1;
                end
            endcase
        end
    end

endmodule // mbdc_show_cycle

`default_nettype wire

/* rtl/mbdc_top.v */
// module base decode and configuration: base locator, block decode,
// unit_config word, debug-halt gating, show cycles and arbitration gate
// assumes one internal bus access per busReq pulse, on clk, from the core
//
// Contract
// - block start is the upper 20 base bits; 4-kbyte granularity only.
// - masked address space skips internal select; cycle runs externally.
// - mask bit 8 covers codes 1xxx, bit 7..0 cover 0111..0000.
// - mask bit one excludes the space; zero allows internal decode.
// - valid flag clear: base ignored, no internal register reachable.
// - base locator accesses complete internally, never on the external bus.
// - base locator reached as a longword at fixed cpu-space address.
// - unit_config readable and writable at any time, no sequence limits.
// - timers bit with debug halt stops watchdog and periodic timer.
// - busmon bit with debug halt disables the bus monitor.
// - full-irq bit: seven requests, autovector; else four requests, four selects.
// - show cycles drive address, data, control but not address strobe.
// - show-cycle data valid by falling edge after data strobe negation.
// - no show cycles: no external data, both strobes unasserted.
// - mirror field 00 none+arb, 01 show no arb, 1x show+arb.
// - arbitration disabled: external bus requests ignored until re-enabled.
// - priv bit set: shared registers need supervisor data; user write faults.
// - priv bit clear: shared registers open to both privilege levels.
// - debug halt asserted on breakpoint while background debug enabled.
// - irq priority field resets to ones; zero makes irqs extraneous.
`timescale 1ns/1ps
`default_nettype none
`include "mbdc_defines.vh"

module mbdc_top (
    input wire clk,
    input wire rst_b,
    input wire busReq,
    input wire busWrite,
    input wire busLong,
    input wire [31:0] busAddr,
    input wire [3:0] busFc,
    input wire [31:0] busWdata,
    input wire [31:0] intRdata,
    input wire bkptHit,
    input wire bdmEnable,
    input wire extBusReq,
    output reg busAck,
    output reg busFault,
    output reg [31:0] busRdata,
    output reg extAccess,
    output reg intSelect,
    output reg [11:0] intOffset,
    output reg debugHalt,
    output wire timersStop,
    output wire busMonStop,
    output wire fullIrqMode,
    output wire [2:0] irqInputCount,
    output wire [2:0] chipSelCount,
    output wire showCycleEn,
    output wire arbEnable,
    output wire [3:0] irqArbLevel,
    output wire irqExtraneous,
    output wire extBusGrantReq,
    output wire [31:0] extAddr,
    output wire extAddrOe,
    output wire [31:0] extData,
    output wire extDataOe,
    output wire extDataStrobe_b,
    output wire extAddrStrobe_b
);

    // ==========================================================
    // storage
    reg [15:0] baseHi;
    reg [15:0] baseLo;
    reg [15:0] unitConfig;
    reg extReqMeta;
    reg extReqSync;

    // ==========================================================
    // field views
    wire [19:0] baseField;
    wire [8:0] spaceMaskBits;
    wire baseValid;
    wire [1:0] mirrorCycleSel;
    wire privOnlyRegs;

    // block base is the upper 20 locator bits
    assign baseField = {baseHi, baseLo[15:`MBDC_LO_BASE_LSB]};
    assign spaceMaskBits = baseLo[`MBDC_LO_MASK_MSB:`MBDC_LO_MASK_LSB];
    assign baseValid = baseLo[`MBDC_LO_VALID_BIT];
    assign mirrorCycleSel = unitConfig[`MBDC_UCFG_MIRROR_MSB:`MBDC_UCFG_MIRROR_LSB];
    assign privOnlyRegs = unitConfig[`MBDC_UCFG_PRIV_BIT];

    // ==========================================================
    // function code to mask bit, one compare per bit 7..0, bit 8 from code bit 3
    wire [8:0] spaceHit;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_space
            // bit 7 down to 0 covers codes 0111 down to 0000
            assign spaceHit[gi] = ({28'h0000000, busFc} == gi);
        end
    endgenerate
    assign spaceHit[8] = busFc[3];

    // a set bit removes the space from internal decode
    wire spaceMasked;
    assign spaceMasked = |(spaceHit & spaceMaskBits);

    // ==========================================================
    // address decode of the current request
    wire isBaseLoc;
    wire blockHit;
    wire [11:0] offset;
    wire isUnitCfg;
    wire isShared;
    wire supData;
    wire sharedDenied;
    wire supDenied;

    // base locator sits at a fixed cpu-space address
    assign isBaseLoc = (busFc == `MBDC_FC_CPU)
        && ({busAddr[31:2], 2'b00} == `MBDC_BASELOC_ADDR);
    // internal block only when valid, base matches and space not masked
    assign blockHit = !isBaseLoc && baseValid
        && (busAddr[31:12] == baseField)
        && !spaceMasked;
    assign offset = busAddr[11:0];
    assign isUnitCfg = ({offset[11:1], 1'b0} == `MBDC_UCFG_OFFSET);
    assign isShared = (offset >= `MBDC_SHARED_LO) && (offset <= `MBDC_SHARED_HI);
    assign supData = (busFc == `MBDC_FC_SUP_DATA);
    // shared registers check privilege only with the priv bit set
    assign sharedDenied = isShared && privOnlyRegs && !supData;
    // unit_config itself is supervisor only
    assign supDenied = isUnitCfg && !busFc[2];

    // ==========================================================
    // base locator write data per half
    wire wrHi;
    wire wrLo;
    wire [15:0] wrHiData;
    wire [15:0] wrLoData;

    // longword writes both halves; a word write picks a half by address bit 1
    assign wrHi = busReq && busWrite && isBaseLoc && (busLong || !busAddr[1]);
    assign wrLo = busReq && busWrite && isBaseLoc && (busLong || busAddr[1]);
    assign wrHiData = (busLong || busAddr[1]) ? busWdata[31:16] : busWdata[15:0];
    assign wrLoData = busWdata[15:0];

    // reset image of the whole locator, split per half
    wire [31:0] baseLocReset;
    assign baseLocReset = `MBDC_BASELOC_RESET;

    // base locator registers, cleared by reset
    always @(posedge clk) begin
        if (!rst_b) begin
            baseHi <= baseLocReset[31:16];
            baseLo <= baseLocReset[15:0];
        end else begin
            if (wrHi) begin
                baseHi <= busLong ? busWdata[31:16] : wrHiData;
            end
            if (wrLo) begin
                // bits 11..10 hold zero
                baseLo <= {wrLoData[15:12], 2'b00, wrLoData[9:0]};
            end
        end
    end

    // ==========================================================
    // unit_config: open to writes at any time
    wire wrCfg;
    assign wrCfg = busReq && busWrite && blockHit && isUnitCfg && !supDenied;

    always @(posedge clk) begin
        if (!rst_b) begin
            unitConfig <= `MBDC_UCFG_RESET;
        end else if (wrCfg) begin
            unitConfig <= busWdata[15:0] & `MBDC_UCFG_WMASK;
        end
    end

    // ==========================================================
    // read data mux
    reg [31:0] next_rdata;
    always @* begin
        next_rdata = 32'h00000000;
        if (isBaseLoc) begin
            if (busLong) begin
                next_rdata = {baseHi, baseLo};
            end else if (busAddr[1]) begin
                next_rdata = {16'h0000, baseLo};
            end else begin
                next_rdata = {16'h0000, baseHi};
            end
        end else if (isUnitCfg) begin
            next_rdata = {16'h0000, unitConfig};
        end
    end

    // ==========================================================
    // answer to the core, one cycle after the request
    always @(posedge clk) begin
        if (!rst_b) begin
            busAck <= 1'b0;
            busFault <= 1'b0;
            busRdata <= 32'h00000000;
            extAccess <= 1'b0;
            intSelect <= 1'b0;
            intOffset <= 12'h000;
        end else begin
            busAck <= 1'b0;
            busFault <= 1'b0;
            extAccess <= 1'b0;
            intSelect <= 1'b0;
            if (busReq) begin
                intOffset <= offset;
                if (isBaseLoc) begin
                    // finished here, nothing goes external
                    busAck <= 1'b1;
                    busRdata <= next_rdata;
                end else if (!blockHit) begin
                    extAccess <= 1'b1;
                end else if (sharedDenied || supDenied) begin
                    // access is dropped and faulted, read or write
                    busFault <= 1'b1;
                end else if (isUnitCfg) begin
                    busAck <= 1'b1;
                    busRdata <= next_rdata;
                end else begin
                    intSelect <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // debug halt from the core's breakpoint in background mode
    always @(posedge clk) begin
        if (!rst_b) begin
            debugHalt <= 1'b0;
        end else begin
            debugHalt <= bkptHit && bdmEnable;
        end
    end

    // timers and bus monitor stop only while halted and enabled
    assign timersStop = debugHalt && unitConfig[`MBDC_UCFG_TIMERS_BIT];
    assign busMonStop = debugHalt && unitConfig[`MBDC_UCFG_BUSMON_BIT];

    // ==========================================================
    // port b role
    assign fullIrqMode = unitConfig[`MBDC_UCFG_FULL_IRQ_SELECT_BIT];
    assign irqInputCount = fullIrqMode ? 3'h7 : 3'h4;
    assign chipSelCount = fullIrqMode ? 3'h0 : 3'h4;

    // ==========================================================
    // interrupt arbitration level
    assign irqArbLevel = unitConfig[`MBDC_UCFG_IRQ_PRIORITY_FIELD_MSB:0];
    assign irqExtraneous = (irqArbLevel == 4'h0);

    // ==========================================================
    // show cycle and arbitration decode
    assign showCycleEn = (mirrorCycleSel != 2'b00);
    assign arbEnable = (mirrorCycleSel != 2'b01);

    // external bus request pin, two-stage synchroniser
    always @(posedge clk) begin
        if (!rst_b) begin
            extReqMeta <= 1'b0;
            extReqSync <= 1'b0;
        end else begin
            extReqMeta <= extBusReq;
            extReqSync <= extReqMeta;
        end
    end

    // requests pass on only while arbitration is enabled
    assign extBusGrantReq = extReqSync && arbEnable;

    // ==========================================================
    // mirror internal transfers when show cycles are on
    wire showStart;
    wire [31:0] showData;
    assign showStart = busReq && blockHit && showCycleEn;
    assign showData = busWrite ? busWdata : (isUnitCfg ? next_rdata : intRdata);

    mbdc_show_cycle u_show (
        .clk(clk),
        .rst_b(rst_b),
        .start(showStart),
        .showAddr(busAddr),
        .showData(showData),
        .extAddr(extAddr),
        .extAddrOe(extAddrOe),
        .extData(extData),
        .extDataOe(extDataOe),
        .extDataStrobe_b(extDataStrobe_b),
        .extAddrStrobe_b(extAddrStrobe_b),
        .busy()
    );

endmodule // mbdc_top

`default_nettype wire

/* sim/mbdc_chk.sv */
// checker: port relations of the base decode and config block
// assumes it is bound into mbdc_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none

module mbdc_chk (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic busReq,
    input wire logic [31:0] busAddr,
    input wire logic [3:0] busFc,
    input wire logic bkptHit,
    input wire logic bdmEnable,
    input wire logic busAck,
    input wire logic extAccess,
    input wire logic debugHalt,
    input wire logic timersStop,
    input wire logic busMonStop,
    input wire logic fullIrqMode,
    input wire logic [2:0] irqInputCount,
    input wire logic [2:0] chipSelCount,
    input wire logic showCycleEn,
    input wire logic arbEnable,
    input wire logic [3:0] irqArbLevel,
    input wire logic irqExtraneous,
    input wire logic extBusGrantReq,
    input wire logic extBusReq,
    input wire logic [31:0] extData,
    input wire logic extAddrOe,
    input wire logic extDataOe,
    input wire logic extDataStrobe_b,
    input wire logic extAddrStrobe_b
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // ==========================================================
    // show cycle steps
    sequence s_drive;
        extDataOe && extAddrOe;
    endsequence
    sequence s_valid;
        extDataStrobe_b && $stable(extData) ##1 extDataOe && $stable(extData);
    endsequence

    // ==========================================================
    // properties
    property p_loc;
        busReq && busAddr == 32'h0003FF00 && busFc == 4'h7 |=> busAck && !extAccess;
    endproperty
    property p_show;
        $fell(extDataStrobe_b) |-> s_drive ##1 s_valid;
    endproperty
    property p_noshow;
        !showCycleEn && !extDataOe |=> !extDataOe && extDataStrobe_b;
    endproperty
    property p_astb;
        extAddrStrobe_b;
    endproperty
    property p_arb;
        !showCycleEn |-> arbEnable;
    endproperty
    property p_grant;
        $past(rst_b) && $past(rst_b, 2)
            |-> extBusGrantReq == ($past(extBusReq, 2) && arbEnable);
    endproperty
    property p_halt;
        bkptHit && bdmEnable |=> debugHalt;
    endproperty
    property p_frz;
        timersStop || busMonStop |-> debugHalt;
    endproperty
    property p_irq;
        irqInputCount == (fullIrqMode ? 3'h7 : 3'h4) && chipSelCount == (fullIrqMode ? 3'h0 : 3'h4);
    endproperty
    property p_irq_priority_field;
        irqExtraneous == (irqArbLevel == 4'h0);
    endproperty

    a_loc: assert property (p_loc) else $error("locator access not kept inside");
    a_show: assert property (p_show) else $error("show cycle steps wrong");
    a_noshow: assert property (p_noshow) else $error("pins driven without show");
    a_astb: assert property (p_astb) else $error("address strobe asserted");
    a_arb: assert property (p_arb) else $error("arbitration off without show");
    a_grant: assert property (p_grant) else $error("request passed while arb off");
    a_halt: assert property (p_halt) else $error("debug halt missing");
    a_frz: assert property (p_frz) else $error("counters stopped without halt");
    a_irq: assert property (p_irq) else $error("port b counts wrong");
    a_irq_priority_field: assert property (p_irq_priority_field) else $error("extraneous flag wrong");
endmodule // mbdc_chk

bind mbdc_top mbdc_chk chk_u (.clk, .rst_b, .busReq, .busAddr, .busFc, .bkptHit, .bdmEnable,
    .busAck, .extAccess, .debugHalt, .timersStop, .busMonStop, .fullIrqMode, .irqInputCount,
    .chipSelCount, .showCycleEn, .arbEnable, .irqArbLevel, .irqExtraneous, .extBusGrantReq,
    .extBusReq,
    .extData, .extAddrOe, .extDataOe, .extDataStrobe_b, .extAddrStrobe_b);
`default_nettype wire

/* sim/mbdc_ext_peer.sv */
// external peer: bus requester and other-register read data
// assumes the bench steers want and rude between clock edges
`timescale 1ns/1ps
`default_nettype none

module mbdc_ext_peer (
    input wire logic clk,
    input wire logic want,
    input wire logic rude,
    input wire logic showCycleEn,
    input wire logic arbEnable,
    output logic extBusReq,
    output logic [31:0] intRdata
);
    // holds off during show cycles without arbitration unless told to misbehave
    assign extBusReq = want && (rude || !(showCycleEn && !arbEnable));
    // read data of the other registers changes every cycle
    logic [31:0] rdWord = 32'h5A5A5A5A;
    assign intRdata = rdWord;
    always @(posedge clk) begin
        rdWord <= rdWord + 32'h01010101;
    end
endmodule // mbdc_ext_peer
`default_nettype wire

/* sim/mbdc_top_test.sv */
// testbench: core accesses with queued expectations, config and show checks
// assumes mbdc_top, mbdc_ext_peer and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "mbdc_defines.vh"
`define CMP(nm, e, s) begin n_tests++; if ((s) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end

module mbdc_top_test;
    localparam logic [31:0] LOC = 32'h0003FF00;
    localparam logic [31:0] BLK = 32'hFFFFF000;
    localparam logic [1:0] kAck = 2'h0, kFault = 2'h1, kExt = 2'h2, kInt = 2'h3;
    logic clk = 1'b0, rst_b = 1'b0, busReq = 1'b0, busWrite = 1'b0, busLong = 1'b0;
    logic bkptHit = 1'b0, bdmEnable = 1'b0, want = 1'b0, rude = 1'b0, extBusReq;
    logic [31:0] busAddr = 32'h0, busWdata = 32'h0, seed = 32'h48, r, intRdata;
    logic [3:0] busFc = 4'h0;
    logic busAck, busFault, extAccess, intSelect, debugHalt, timersStop, busMonStop;
    logic fullIrqMode, showCycleEn, arbEnable, irqExtraneous, extBusGrantReq;
    logic extAddrOe, extDataOe, extDataStrobe_b, extAddrStrobe_b;
    logic [31:0] busRdata, extAddr, extData;
    logic [11:0] intOffset;
    logic [2:0] irqInputCount, chipSelCount;
    logic [3:0] irqArbLevel;
    logic [35:0] notes[$];
    logic [35:0] nt;
    int num_errors = 0, n_tests = 0;

    mbdc_top dut_u (.clk, .rst_b, .busReq, .busWrite, .busLong, .busAddr, .busFc, .busWdata,
        .intRdata, .bkptHit, .bdmEnable, .extBusReq, .busAck, .busFault, .busRdata, .extAccess,
        .intSelect, .intOffset, .debugHalt, .timersStop, .busMonStop, .fullIrqMode,
        .irqInputCount, .chipSelCount, .showCycleEn, .arbEnable, .irqArbLevel, .irqExtraneous,
        .extBusGrantReq, .extAddr, .extAddrOe, .extData, .extDataOe, .extDataStrobe_b,
        .extAddrStrobe_b);
    mbdc_ext_peer peer_u (.clk, .want, .rude, .showCycleEn, .arbEnable, .extBusReq, .intRdata);

    // 40 MHz clock
    always #12.5 clk = ~clk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // one core access; note: check high, check low, answer kind, data
    task automatic acc(input logic w, input logic [31:0] a, input logic [3:0] fc,
            input logic [31:0] d, input logic [1:0] k, input logic [1:0] m);
        @(negedge clk);
        busReq = 1'b1;
        busWrite = w;
        busLong = (a == LOC);
        busAddr = a;
        busFc = fc;
        busWdata = d;
        notes.push_back({m, k, d});
    endtask

    task automatic idle(input int n);
        @(negedge clk);
        busReq = 1'b0;
        repeat (n) @(negedge clk);
    endtask

    // write unit_config, then read it back
    task automatic cfg(input logic [15:0] v);
        acc(1'b1, BLK, 4'h5, {16'h0, v}, kAck, 2'h0);
        idle(4);
        acc(1'b0, BLK, 4'h5, {16'h0, v & `MBDC_UCFG_WMASK}, kAck, 2'h1);
        idle(4);
    endtask

    // match each answer against the oldest note
    always @(negedge clk) begin
        if (rst_b && (busAck | busFault | extAccess | intSelect)) begin
            nt = notes.pop_front();
            `CMP("answer kind", nt[33:32], {extAccess | intSelect, busFault | intSelect})
            if (nt[34]) `CMP("read low", nt[15:0], busRdata[15:0])
            if (nt[35]) `CMP("read high", nt[31:16], busRdata[31:16])
        end
    end

    task automatic end_sim();
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        #(25 * 20000);
        num_errors++;
        end_sim();
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        `CMP("arb level", 4'hF, irqArbLevel)
        acc(1'b0, LOC, 4'h7, 32'h0, kAck, 2'h3);
        acc(1'b0, BLK + 32'h100, 4'h5, 32'h0, kExt, 2'h0);
        r = xs();
        acc(1'b1, LOC, 4'h7, r, kAck, 2'h0);
        acc(1'b0, LOC, 4'h7, r & 32'hFFFFF3FF, kAck, 2'h3);
        acc(1'b1, LOC, 4'h7, 32'hFFFFF001, kAck, 2'h0);
        acc(1'b0, LOC + 2, 4'h7, 32'hF001, kAck, 2'h1);
        acc(1'b0, BLK + 32'hFFE, 4'h5, 32'h0, kInt, 2'h0);
        acc(1'b0, BLK - 2, 4'h5, 32'h0, kExt, 2'h0);
        acc(1'b1, BLK + 32'h10, 4'h1, 32'h0, kFault, 2'h0);
        acc(1'b0, BLK + 32'h10, 4'h5, 32'h0, kInt, 2'h0);
        idle(4);
        cfg(16'h0000);
        acc(1'b1, BLK + 32'h10, 4'h1, 32'h0, kInt, 2'h0);
        `CMP("extraneous", 1'b1, irqExtraneous)
        for (int i = 0; i < 9; i++) begin
            acc(1'b1, LOC + 2, 4'h7, 32'hF001 | (32'h2 << i), kAck, 2'h0);
            for (int f = 0; f < 16; f++) begin
                acc(1'b0, BLK + 32'h100, f[3:0], 32'h0,
                    ((f[3] ? 8 : f) == i) ? kExt : kInt, 2'h0);
            end
        end
        acc(1'b1, LOC + 2, 4'h7, 32'hF001, kAck, 2'h0);
        idle(4);
        want = 1'b1;
        rude = 1'b1;
        for (int m = 0; m < 4; m++) begin
            cfg({6'h00, m[1:0], 8'h0F});
            `CMP("show", m != 0, showCycleEn)
            `CMP("grant", m != 1, extBusGrantReq)
        end
        r = xs();
        acc(1'b1, BLK + 32'h100, 4'h5, r, kInt, 2'h0);
        idle(0);
        `CMP("show addr", BLK + 32'h100, extAddr)
        `CMP("show strobe", 1'b0, extDataStrobe_b)
        `CMP("offset", 12'h100, intOffset)
        @(negedge clk);
        `CMP("show data", r, extData)
        `CMP("strobe off", 1'b1, extDataStrobe_b)
        idle(4);
        bkptHit = 1'b1;
        for (int h = 0; h < 16; h++) begin
            cfg({1'b0, h[2:0], 4'h0, 8'h0F});
            bdmEnable = h[3];
            repeat (2) @(negedge clk);
            `CMP("halt", h[3], debugHalt)
            `CMP("timers", h[3] & h[2], timersStop)
            `CMP("busmon", h[3] & h[1], busMonStop)
            `CMP("irq lines", h[0] ? 3'h7 : 3'h4, irqInputCount)
        end
        acc(1'b0, BLK + 32'h100, 4'h5, 32'h0, kInt, 2'h0);
        idle(1);
        `CMP("no show oe", 1'b0, extDataOe)
        idle(2);
        `CMP("notes left", 0, notes.size())
        end_sim();
    end
endmodule // mbdc_top_test
`default_nettype wire
